// ---- core/fpl_map.vh ----
// constants for the fast parallel load port
`ifndef FPL_MAP_VH
`define FPL_MAP_VH
`define FPL_CLK_NS 50
`define FPL_POR_NS 100000
`define FPL_POR_CYC ((`FPL_POR_NS + `FPL_CLK_NS - 1) / `FPL_CLK_NS)
`define FPL_MODE_X8 2'h0
`define FPL_MODE_X16 2'h1
`define FPL_MODE_X32 2'h2
`define FPL_INIT_EDGES 2'h2
`define FPL_ARM_CYC 2'h3
`define FPL_INIT_BIT 0
`define FPL_WORDS_RST 16'h0010
`define FPL_FIFO_W 32
`define FPL_FIFO_D 8
`endif

// ---- core/fpl_load_port.v ----
// fast parallel configuration load port with word fifo
`include "fpl_map.vh"

module fpl_fifo #(
    parameter W = 32,
    parameter D = 8
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [W-1:0] mem [0:D-1];
    reg [3:0] wr_q;
    reg [3:0] rd_q;
    wire [3:0] used = wr_q - rd_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (used < D);
    assign out_valid = (used != 4'h0);
    assign out_data = mem[rd_q[2:0]];
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q[2:0]] <= in_data;
        end
    end
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= 4'h0;
            rd_q <= 4'h0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 4'h1;
            end
            if (pop) begin
                rd_q <= rd_q + 4'h1;
            end
        end
    end
endmodule // fpl_fifo

module fpl_load_port #(
    parameter POR_CYC = `FPL_POR_CYC
) (
    input wire clk_sys,
    input wire rst_b,
    input wire reconfig_request_n,
    input wire cfg_clock,
    input wire [31:0] cfg_data,
    input wire [1:0] width_mode,
    input wire [15:0] image_words,
    output reg device_status_n_o,
    output reg device_status_n_oe,
    output reg load_complete_o,
    output reg load_complete_oe,
    output reg init_done_o,
    output reg init_done_oe,
    output reg user_mode,
    output reg data_pins_user,
    output reg [31:0] word_data,
    output reg word_valid,
    input wire word_ready
);
    localparam S_POR = 3'h0;
    localparam S_RESET = 3'h1;
    localparam S_LOAD = 3'h2;
    localparam S_INIT = 3'h3;
    localparam S_USER = 3'h4;
    localparam S_ERR = 3'h5;
    reg [2:0] st_q;
    reg [31:0] por_q;
    reg [2:0] rcf_q;
    reg [2:0] clk_q;
    reg [31:0] d1_q;
    reg [31:0] d2_q;
    reg [15:0] cnt_q;
    reg [1:0] fall_q;
    reg [1:0] arm_q;
    reg init_en_q;
    wire rcf_low = !rcf_q[1];
    wire rise = clk_q[1] && !clk_q[2];
    wire fall = !clk_q[1] && clk_q[2];
    wire f_ready;
    wire [31:0] f_data;
    wire f_valid;
    reg [31:0] lane;
    always @* begin
        case (width_mode)
            `FPL_MODE_X8: lane = {24'h000000, d2_q[7:0]};
            `FPL_MODE_X16: lane = {16'h0000, d2_q[15:0]};
            default: lane = d2_q;
        endcase
    end
    wire take = (st_q == S_LOAD) && rise && (cnt_q != image_words);
    fpl_fifo #(.W(`FPL_FIFO_W), .D(`FPL_FIFO_D)) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_data(lane),
        .in_valid(take),
        .in_ready(f_ready),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(word_ready || !word_valid)
    );
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rcf_q <= 3'h7;
            clk_q <= 3'h0;
            d1_q <= 32'h00000000;
            d2_q <= 32'h00000000;
        end else begin
            rcf_q <= {rcf_q[1:0], reconfig_request_n};
            clk_q <= {clk_q[1:0], cfg_clock};
            d1_q <= cfg_data;
            d2_q <= d1_q;
        end
    end
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= S_POR;
            por_q <= 32'h00000000;
            cnt_q <= 16'h0000;
            fall_q <= 2'h0;
            arm_q <= 2'h0;
            init_en_q <= 1'b0;
            word_data <= 32'h00000000;
            word_valid <= 1'b0;
        end else begin
            if (f_valid && (word_ready || !word_valid)) begin
                word_data <= f_data;
                word_valid <= 1'b1;
            end else if (word_ready) begin
                word_valid <= 1'b0;
            end
            case (st_q)
                S_POR: begin
                    por_q <= por_q + 32'h1;
                    if (por_q >= POR_CYC - 1) begin
                        st_q <= S_RESET;
                    end
                end
                S_RESET: begin
                    cnt_q <= 16'h0000;
                    fall_q <= 2'h0;
                    arm_q <= 2'h0;
                    if (!rcf_low) begin
                        st_q <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    if (rcf_low) begin
                        st_q <= S_RESET;
                    end else if (take && !f_ready) begin
                        st_q <= S_ERR;
                    end else if (take) begin
                        if (cnt_q == 16'h0000) begin
                            init_en_q <= lane[`FPL_INIT_BIT];
                        end
                        cnt_q <= cnt_q + 16'h1;
                    end else if (cnt_q == image_words) begin
                        st_q <= S_INIT;
                    end
                end
                S_INIT: begin
                    if (rcf_low) begin
                        st_q <= S_RESET;
                    end else if (arm_q != `FPL_ARM_CYC) begin
                        // skip falls launched before load complete rose
                        arm_q <= arm_q + 2'h1;
                    end else if (fall) begin
                        fall_q <= fall_q + 2'h1;
                        if (fall_q == `FPL_INIT_EDGES - 2'h1) begin
                            st_q <= S_USER;
                        end
                    end
                end
                S_USER: begin
                    if (rcf_low) begin
                        st_q <= S_RESET;
                    end
                end
                S_ERR: begin
                    if (rcf_low) begin
                        st_q <= S_RESET;
                    end
                end
                default: st_q <= S_POR;
            endcase
        end
    end
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            device_status_n_o <= 1'b0;
            device_status_n_oe <= 1'b1;
            load_complete_o <= 1'b0;
            load_complete_oe <= 1'b1;
            init_done_o <= 1'b0;
            init_done_oe <= 1'b0;
            user_mode <= 1'b0;
            data_pins_user <= 1'b0;
        end else begin
            device_status_n_o <= 1'b0;
            device_status_n_oe <= !(st_q == S_LOAD || st_q == S_INIT || st_q == S_USER);
            load_complete_o <= 1'b0;
            load_complete_oe <= !(st_q == S_INIT || st_q == S_USER);
            init_done_o <= 1'b0;
            init_done_oe <= init_en_q && (st_q == S_INIT);
            user_mode <= (st_q == S_USER);
            data_pins_user <= (st_q == S_INIT || st_q == S_USER);
        end
    end
endmodule // fpl_load_port

// ---- testbench/fpl_load_port_assertions.sv ----
// assertions on the load port outputs
module fpl_chk #(
    parameter POR_CYC = 4
) (
    input logic clk_sys,
    input logic rst_b,
    input logic reconfig_request_n,
    input logic device_status_n_oe,
    input logic load_complete_oe,
    input logic init_done_oe,
    input logic user_mode,
    input logic data_pins_user,
    input logic [31:0] word_data,
    input logic word_valid,
    input logic word_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_user_released: assert property (user_mode |-> !device_status_n_oe)
        else $error("status pulled in user mode");
    chk_restart_low: assert property (!reconfig_request_n [*5] |-> !user_mode)
        else $error("no restart on request");
    chk_por_hold: assert property ($rose(rst_b) |-> device_status_n_oe [*4])
        else $error("status released too early");
    chk_done_low: assert property (device_status_n_oe |-> load_complete_oe)
        else $error("load complete early");
    chk_clk_ignored: assert property (user_mode && reconfig_request_n |=> user_mode)
        else $error("user mode left");
    chk_pins_user: assert property (user_mode |-> data_pins_user)
        else $error("data pins kept");
    chk_init_low: assert property (init_done_oe |-> !user_mode && !load_complete_oe)
        else $error("init done pulled outside init");
    chk_word_stands: assert property (word_valid && !word_ready && reconfig_request_n
        |=> word_valid && $stable(word_data)) else $error("word dropped");
    cover property ($rose(user_mode));
    cover property (word_valid && word_ready);
    cover property (init_done_oe);
endmodule // fpl_chk

// ---- testbench/fpl_host.sv ----
// host model driving the configuration pins
module fpl_host (
    input logic clk_sys,
    input logic device_status_n_oe,
    output logic reconfig_request_n,
    output logic cfg_clock,
    output logic [31:0] cfg_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reconfig_request_n = 1'b1;
        cfg_clock = 1'b0;
        cfg_data = 32'h0000_0000;
    end
    task restart;
        int k;
        begin
            reconfig_request_n <= 1'b0;
            repeat (6) @(posedge clk_sys);
            reconfig_request_n <= 1'b1;
            for (k = 0; k < 200 && device_status_n_oe !== 1'b0; k++)
                @(posedge clk_sys);
        end
    endtask
    task word(input logic [31:0] w);
        begin
            cfg_data <= w;
            repeat (2) @(posedge clk_sys);
            cfg_clock <= 1'b1;
            repeat (4) @(posedge clk_sys);
            cfg_clock <= 1'b0;
            cfg_data <= ~w;
            repeat (2) @(posedge clk_sys);
        end
    endtask
endmodule // fpl_host

// ---- testbench/fpl_load_port_tb.sv ----
// bench for the fast parallel load port
`include "fpl_map.vh"
module fpl_load_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic reconfig_request_n, cfg_clock, device_status_n_oe, load_complete_oe, init_done_oe;
    logic user_mode, data_pins_user, word_valid, word_ready = 1'b0;
    logic [31:0] cfg_data, word_data;
    logic [1:0] width_mode = `FPL_MODE_X32;
    logic [15:0] image_words = 16'h0008;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    fpl_load_port #(.POR_CYC(4)) u_dut (.clk_sys, .rst_b, .reconfig_request_n, .cfg_clock,
        .cfg_data, .width_mode, .image_words, .device_status_n_o(), .device_status_n_oe,
        .load_complete_o(), .load_complete_oe, .init_done_o(), .init_done_oe, .user_mode,
        .data_pins_user, .word_data, .word_valid, .word_ready);
    fpl_host u_host (.clk_sys, .device_status_n_oe, .reconfig_request_n, .cfg_clock, .cfg_data);
    initial forever #25 clk_sys = ~clk_sys;
    task summarize;
        begin
            $display("miscompares %0d n_tests %0d", miscompares, n_tests);
            if (miscompares == 0 && n_tests > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            summarize;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            n_tests++;
            if (g !== e) begin
                miscompares++;
                $display("BAD %s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task t_por;
        begin
            chk("por", 3, {device_status_n_oe, load_complete_oe});
            repeat (12) @(posedge clk_sys);
            chk("por_end", 0, device_status_n_oe);
        end
    endtask
    task t_overflow;
        int i;
        begin
            image_words <= 16'h000C;
            u_host.restart;
            for (i = 0; i < 11; i++)
                u_host.word(32'h5A5A_0000 + i);
            chk("ovf", 3, {device_status_n_oe, load_complete_oe});
            word_ready <= 1'b1;
            repeat (20) @(posedge clk_sys);
        end
    endtask
    task t_load(input logic [1:0] m);
        logic [31:0] mask;
        int i;
        begin
            mask = (m == `FPL_MODE_X8) ? 32'h0000_00FF : 32'hFFFF_FFFF;
            mask = (m == `FPL_MODE_X16) ? 32'h0000_FFFF : mask;
            width_mode <= m;
            image_words <= 16'h0008;
            word_ready <= 1'b0;
            u_host.restart;
            for (i = 0; i < 8; i++) begin
                chk("lc_oe", 1, load_complete_oe);
                u_host.word(32'h9E3C_5A10 + i + (i == 0 ? m[0] : 0));
            end
            repeat (6) @(posedge clk_sys);
            chk("lc_init", {1'b0, m[0], 1'b0}, {load_complete_oe, init_done_oe, user_mode});
            word_ready <= 1'b1;
            i = 0;
            repeat (40) begin
                @(negedge clk_sys);
                if (word_valid === 1'b1) begin
                    chk("word", (32'h9E3C_5A10 + i + (i == 0 ? m[0] : 0)) & mask, word_data);
                    i++;
                end
            end
            chk("count", 8, i);
            @(posedge clk_sys);
            u_host.word(32'h0000_0000);
            repeat (4) @(posedge clk_sys);
            chk("one_edge", 0, user_mode);
            u_host.word(32'h0000_0000);
            repeat (4) @(posedge clk_sys);
            chk("user", 3, {user_mode, data_pins_user});
            chk("od", 0, {device_status_n_oe, load_complete_oe, init_done_oe});
            u_host.word(32'h1234_5678);
            chk("ign", 2, {user_mode, word_valid});
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_por;
        t_overflow;
        t_load(`FPL_MODE_X8);
        t_load(`FPL_MODE_X16);
        t_load(`FPL_MODE_X32);
        summarize;
    end
endmodule // fpl_load_port_tb
bind fpl_load_port fpl_chk #(.POR_CYC(POR_CYC)) u_chk (.clk_sys, .rst_b, .reconfig_request_n,
    .device_status_n_oe, .load_complete_oe, .init_done_oe, .user_mode, .data_pins_user,
    .word_data, .word_valid, .word_ready);
